/* File: verilog/lcdcs_regs.sv */
// Control register bank and drive level generator for the shared LCD common/segment pins.
//
// Added by the designer: strobed register access and the placing of the registers.
`timescale 1ns/100ps
module lcdcs_regs
  import lcdcs_pkg::*;
#(
  parameter int NPIN = LCDCS_NPIN
) (
  input wire logic sys_clk_in, // System clock, 100 MHz
  input wire logic reset_in, // Asynchronous reset, active high
  input wire logic [LCDCS_ADDR_W-1:0] reg_addr_in, // Register address
  input wire logic [LCDCS_DATA_W-1:0] reg_wdata_in, // Write data
  input wire logic reg_wr_in, // Write strobe
  input wire logic reg_rd_in, // Read strobe
  output logic [LCDCS_DATA_W-1:0] reg_rdata_out, // Read data, cycle after strobe
  input wire logic [NPIN-1:0] io_data_in, // Shared I/O data bits per pin
  input wire logic [NPIN-1:0] lcd_func_in, // Pin mux hands pin to LCD stage
  output logic lcd_driver_on_out, // Driver master enable
  output logic frame_out, // Current frame phase
  output logic [1:0] bias_resistor_select_out, // Bias ladder code
  output logic [3:0] bias_ladder_out, // One-hot ladder switch, bit 0 highest R
  output logic [NPIN-1:0] common_or_segment_role_out, // 0 common, 1 segment
  output logic [NPIN-1:0] pin_active_out, // Pin driven by LCD stage
  output lcdcs_levels_t pin_level_out // Level code per pin
);

  // ----------------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------------
  lcdcs_state_t st;
  lcdcs_state_t next_st;
  logic [NPIN-1:0] role;
  logic [NPIN-1:0] next_active;
  lcdcs_levels_t next_level;
  logic [LCDCS_DATA_W-1:0] read_mux;

  // Pins 4, 5, 10 and 13 have no select bit; they stay common and idle.
  assign role = {st.sel_high[3:0], st.sel_mid[7:6], 1'b0, st.sel_mid[4:3], 1'b0,
                 st.sel_mid[1:0], st.sel_low[7:6], 2'b00, st.sel_low[3:0]};

  // Direction registers are deliberately not looked at here.
  assign next_active = {NPIN{st.on}} & lcd_func_in & LCDCS_PIN_IMPL;

  // ----------------------------------------------------------------------------
  // Per-pin level selection
  // ----------------------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi++) begin : g_pin
      lcdcs_level_cell u_cell (
        .active_in(next_active[gi]),
        .frame_in(st.frame),
        .role_in(role[gi]),
        .data_in(io_data_in[gi]),
        .level_out(next_level[gi])
      );
    end
  endgenerate

  // ----------------------------------------------------------------------------
  // Read multiplexer
  // ----------------------------------------------------------------------------
  always_comb begin
    case (reg_addr_in)
      LCDCS_OFF_CTRL: begin
        read_mux = {st.frame, st.bias, st.on, 4'h0};
      end
      LCDCS_OFF_SEL_LOW: begin
        read_mux = st.sel_low;
      end
      LCDCS_OFF_SEL_MID: begin
        read_mux = st.sel_mid;
      end
      LCDCS_OFF_SEL_HIGH: begin
        read_mux = {2'h0, st.sel_high};
      end
      default: begin
        read_mux = 8'h00;
      end
    endcase
  end

  // ----------------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.rdata = reg_rd_in ? read_mux : 8'h00;
    next_st.active = next_active;
    next_st.level = next_level;
    if (reg_wr_in) begin
      case (reg_addr_in)
        LCDCS_OFF_CTRL: begin
          next_st.frame = reg_wdata_in[LCDCS_CTRL_FRAME_BIT];
          next_st.bias = reg_wdata_in[LCDCS_CTRL_BIAS_MSB:LCDCS_CTRL_BIAS_LSB];
          next_st.on = reg_wdata_in[LCDCS_CTRL_ON_BIT];
        end
        LCDCS_OFF_SEL_LOW: begin
          next_st.sel_low = reg_wdata_in;
        end
        LCDCS_OFF_SEL_MID: begin
          next_st.sel_mid = reg_wdata_in;
        end
        LCDCS_OFF_SEL_HIGH: begin
          next_st.sel_high = reg_wdata_in[LCDCS_SEL_HIGH_W-1:0];
        end
        default: begin
          next_st = next_st;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      st.frame <= LCDCS_RST_FRAME;
      st.bias <= LCDCS_RST_BIAS;
      st.on <= LCDCS_RST_ON;
      st.sel_low <= LCDCS_RST_SEL_LOW;
      st.sel_mid <= LCDCS_RST_SEL_MID;
      st.sel_high <= LCDCS_RST_SEL_HIGH;
      st.rdata <= 8'h00;
      st.active <= '0;
      st.level <= '0;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------------
  assign reg_rdata_out = st.rdata;
  assign lcd_driver_on_out = st.on;
  assign frame_out = st.frame;
  assign bias_resistor_select_out = st.bias;
  assign bias_ladder_out = 4'h1 << st.bias;
  assign common_or_segment_role_out = role;
  assign pin_active_out = st.active;
  assign pin_level_out = st.level;

  // ----------------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------------
  property p_bias_ladder;
    @(posedge sys_clk_in) disable iff (reset_in)
    (reg_wr_in && reg_addr_in == LCDCS_OFF_CTRL) |=>
      (bias_ladder_out == (4'h1 << $past(reg_wdata_in[6:5])));
  endproperty
  a_bias_ladder: assert property (p_bias_ladder) else $error("bias ladder mismatch");

  property p_driver_on;
    @(posedge sys_clk_in) disable iff (reset_in)
    (reg_wr_in && reg_addr_in == LCDCS_OFF_CTRL) |=>
      (lcd_driver_on_out == $past(reg_wdata_in[4]));
  endproperty
  a_driver_on: assert property (p_driver_on) else $error("driver-on bit not taken");

  property p_off_ground;
    @(posedge sys_clk_in) disable iff (reset_in)
    !lcd_driver_on_out |=> (pin_level_out == '0) && (pin_active_out == '0);
  endproperty
  a_off_ground: assert property (p_off_ground) else $error("pin driven while off");

  property p_ctrl_low_zero;
    @(posedge sys_clk_in) disable iff (reset_in)
    (reg_rd_in && reg_addr_in == LCDCS_OFF_CTRL) |=>
      (reg_rdata_out[3:0] == 4'h0) && (reg_rdata_out[4] == lcd_driver_on_out);
  endproperty
  a_ctrl_low_zero: assert property (p_ctrl_low_zero) else $error("control readback wrong");

  property p_role_low;
    @(posedge sys_clk_in) disable iff (reset_in)
    (reg_wr_in && reg_addr_in == LCDCS_OFF_SEL_LOW) |=>
      (common_or_segment_role_out[7:6] == $past(reg_wdata_in[7:6])) &&
      (common_or_segment_role_out[3:0] == $past(reg_wdata_in[3:0]));
  endproperty
  a_role_low: assert property (p_role_low) else $error("low role select wrong");

  property p_role_mid;
    @(posedge sys_clk_in) disable iff (reset_in)
    (reg_wr_in && reg_addr_in == LCDCS_OFF_SEL_MID) |=>
      (common_or_segment_role_out[15:14] == $past(reg_wdata_in[7:6])) &&
      (common_or_segment_role_out[12:11] == $past(reg_wdata_in[4:3])) &&
      (common_or_segment_role_out[9:8] == $past(reg_wdata_in[1:0]));
  endproperty
  a_role_mid: assert property (p_role_mid) else $error("mid role select wrong");

  property p_role_high;
    @(posedge sys_clk_in) disable iff (reset_in)
    (reg_wr_in && reg_addr_in == LCDCS_OFF_SEL_HIGH) |=>
      (common_or_segment_role_out[19:16] == $past(reg_wdata_in[3:0]));
  endproperty
  a_role_high: assert property (p_role_high) else $error("high role select wrong");

  property p_high_top_zero;
    @(posedge sys_clk_in) disable iff (reset_in)
    (reg_rd_in && reg_addr_in == LCDCS_OFF_SEL_HIGH) |=>
      (reg_rdata_out[7:6] == 2'h0) && (reg_rdata_out[3:0] == common_or_segment_role_out[19:16]);
  endproperty
  a_high_top_zero: assert property (p_high_top_zero) else $error("high select top bits");

  property p_frame_level;
    @(posedge sys_clk_in) disable iff (reset_in)
    (lcd_driver_on_out && lcd_func_in[1] && !common_or_segment_role_out[1] && io_data_in[1]) |=>
      (pin_level_out[1] == ($past(frame_out) ? LCDCS_LVL_VSS : LCDCS_LVL_VDD));
  endproperty
  a_frame_level: assert property (p_frame_level) else $error("common rail wrong");

  property p_bias_level;
    @(posedge sys_clk_in) disable iff (reset_in)
    (lcd_driver_on_out && lcd_func_in[16] && common_or_segment_role_out[16] && !io_data_in[16]) |=>
      (pin_level_out[16] == ($past(frame_out) ? LCDCS_LVL_THIRD : LCDCS_LVL_TWO_THIRDS));
  endproperty
  a_bias_level: assert property (p_bias_level) else $error("segment bias wrong");

  property p_active;
    @(posedge sys_clk_in) disable iff (reset_in)
    ##1 (pin_active_out == ($past({NPIN{lcd_driver_on_out}}) & $past(lcd_func_in) & LCDCS_PIN_IMPL));
  endproperty
  a_active: assert property (p_active) else $error("pin active wrong");

  property p_reset_zero;
    @(posedge sys_clk_in)
    $fell(reset_in) |-> !lcd_driver_on_out && !frame_out && (bias_resistor_select_out == 2'h0) &&
      (common_or_segment_role_out == '0);
  endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("reset values wrong");

  // ----------------------------------------------------------------------------
  // Bus and pin level cross-checks
  // ----------------------------------------------------------------------------
  property p_bias_select;
    @(posedge sys_clk_in) disable iff (reset_in)
    (reg_wr_in && reg_addr_in == LCDCS_OFF_CTRL) |=>
      (bias_resistor_select_out == $past(reg_wdata_in[6:5]));
  endproperty
  a_bias_select: assert property (p_bias_select) else $error("bias code wrong");

  property p_ladder_hot;
    @(posedge sys_clk_in) disable iff (reset_in)
    $onehot(bias_ladder_out);
  endproperty
  a_ladder_hot: assert property (p_ladder_hot) else $error("ladder not one-hot");

  // Control outputs move only on a control write; a stray change would flicker the panel.
  property p_ctrl_hold;
    @(posedge sys_clk_in) disable iff (reset_in)
    !(reg_wr_in && reg_addr_in == LCDCS_OFF_CTRL) |=>
      $stable(lcd_driver_on_out) && $stable(frame_out) && $stable(bias_resistor_select_out);
  endproperty
  a_ctrl_hold: assert property (p_ctrl_hold) else $error("control moved");

  property p_frame_taken;
    @(posedge sys_clk_in) disable iff (reset_in)
    (reg_wr_in && reg_addr_in == LCDCS_OFF_CTRL) |=>
      (frame_out == $past(reg_wdata_in[7]));
  endproperty
  a_frame_taken: assert property (p_frame_taken) else $error("frame not taken");

  property p_low_read;
    @(posedge sys_clk_in) disable iff (reset_in)
    (reg_rd_in && reg_addr_in == LCDCS_OFF_SEL_LOW) |=>
      (reg_rdata_out[7:6] == common_or_segment_role_out[7:6]) &&
      (reg_rdata_out[3:0] == common_or_segment_role_out[3:0]);
  endproperty
  a_low_read: assert property (p_low_read) else $error("low readback wrong");

  property p_mid_read;
    @(posedge sys_clk_in) disable iff (reset_in)
    (reg_rd_in && reg_addr_in == LCDCS_OFF_SEL_MID) |=>
      (reg_rdata_out[7:6] == common_or_segment_role_out[15:14]) &&
      (reg_rdata_out[4:3] == common_or_segment_role_out[12:11]) &&
      (reg_rdata_out[1:0] == common_or_segment_role_out[9:8]);
  endproperty
  a_mid_read: assert property (p_mid_read) else $error("mid readback wrong");

  // Writes to unmapped indices must leave the pin roles alone as well.
  property p_role_hold;
    @(posedge sys_clk_in) disable iff (reset_in)
    (!reg_wr_in || reg_addr_in == LCDCS_OFF_CTRL || reg_addr_in > LCDCS_OFF_SEL_HIGH) |=>
      $stable(common_or_segment_role_out);
  endproperty
  a_role_hold: assert property (p_role_hold) else $error("role moved");

  property p_unmapped_read;
    @(posedge sys_clk_in) disable iff (reset_in)
    (reg_rd_in && reg_addr_in > LCDCS_OFF_SEL_HIGH) |=> (reg_rdata_out == 8'h00);
  endproperty
  a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read");

  // Stale read data would look like a second read to a master that samples late.
  property p_rdata_idle;
    @(posedge sys_clk_in) disable iff (reset_in)
    !reg_rd_in |=> (reg_rdata_out == 8'h00);
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");

  property p_seg_rail;
    @(posedge sys_clk_in) disable iff (reset_in)
    (lcd_driver_on_out && lcd_func_in[16] && common_or_segment_role_out[16] && io_data_in[16]) |=>
      (pin_level_out[16] == ($past(frame_out) ? LCDCS_LVL_VDD : LCDCS_LVL_VSS));
  endproperty
  a_seg_rail: assert property (p_seg_rail) else $error("segment rail wrong");

  property p_com_bias;
    @(posedge sys_clk_in) disable iff (reset_in)
    (lcd_driver_on_out && lcd_func_in[1] && !common_or_segment_role_out[1] && !io_data_in[1]) |=>
      (pin_level_out[1] == ($past(frame_out) ? LCDCS_LVL_TWO_THIRDS : LCDCS_LVL_THIRD));
  endproperty
  a_com_bias: assert property (p_com_bias) else $error("common bias wrong");

  property p_unshared_pin;
    @(posedge sys_clk_in) disable iff (reset_in)
    !lcd_func_in[0] |=>
      (pin_level_out[0] == LCDCS_LVL_VSS) && !pin_active_out[0];
  endproperty
  a_unshared_pin: assert property (p_unshared_pin) else $error("pin 0 driven");

  property p_gap_pins;
    @(posedge sys_clk_in) disable iff (reset_in)
    (pin_active_out[5:4] == 2'h0) && !pin_active_out[10] && !pin_active_out[13] &&
      (common_or_segment_role_out[5:4] == 2'h0) && !common_or_segment_role_out[13];
  endproperty
  a_gap_pins: assert property (p_gap_pins) else $error("gap pin used");

  // Reset must leave every pin at ground before software has written anything.
  property p_reset_out;
    @(posedge sys_clk_in)
    $fell(reset_in) |-> (reg_rdata_out == 8'h00) && (pin_active_out == '0) &&
      (pin_level_out == '0) && (bias_ladder_out == 4'h1);
  endproperty
  a_reset_out: assert property (p_reset_out) else $error("reset outputs wrong");

endmodule

/* File: verilog/lcdcs_pkg.sv */
// Package with the offsets, field layouts, reset values and level codes of the LCD drive bank.
package lcdcs_pkg;

  // ----------------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------------
  localparam int LCDCS_ADDR_W = 4;
  localparam int LCDCS_DATA_W = 8;
  localparam int LCDCS_NPIN = 20;
  localparam logic [3:0] LCDCS_OFF_CTRL = 4'h0;
  localparam logic [3:0] LCDCS_OFF_SEL_LOW = 4'h1;
  localparam logic [3:0] LCDCS_OFF_SEL_MID = 4'h2;
  localparam logic [3:0] LCDCS_OFF_SEL_HIGH = 4'h3;

  // ----------------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------------
  localparam int LCDCS_CTRL_FRAME_BIT = 7;
  localparam int LCDCS_CTRL_BIAS_MSB = 6;
  localparam int LCDCS_CTRL_BIAS_LSB = 5;
  localparam int LCDCS_CTRL_ON_BIT = 4;
  localparam int LCDCS_SEL_HIGH_W = 6;
  localparam logic [19:0] LCDCS_PIN_IMPL = 20'hFDBCF;

  // ----------------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------------
  localparam logic LCDCS_RST_FRAME = 1'h0;
  localparam logic [1:0] LCDCS_RST_BIAS = 2'h0;
  localparam logic LCDCS_RST_ON = 1'h0;
  localparam logic [7:0] LCDCS_RST_SEL_LOW = 8'h00;
  localparam logic [7:0] LCDCS_RST_SEL_MID = 8'h00;
  localparam logic [5:0] LCDCS_RST_SEL_HIGH = 6'h00;

  // ----------------------------------------------------------------------------
  // Output level codes
  // ----------------------------------------------------------------------------
  localparam logic [1:0] LCDCS_LVL_VSS = 2'h0;
  localparam logic [1:0] LCDCS_LVL_THIRD = 2'h1;
  localparam logic [1:0] LCDCS_LVL_TWO_THIRDS = 2'h2;
  localparam logic [1:0] LCDCS_LVL_VDD = 2'h3;

  typedef logic [LCDCS_NPIN-1:0][1:0] lcdcs_levels_t;

  typedef struct packed {
    logic frame;
    logic [1:0] bias;
    logic on;
    logic [7:0] sel_low;
    logic [7:0] sel_mid;
    logic [5:0] sel_high;
    logic [7:0] rdata;
    logic [LCDCS_NPIN-1:0] active;
    lcdcs_levels_t level;
  } lcdcs_state_t;

endpackage

/* File: verilog/lcdcs_level_cell.sv */
// Per-pin selector of the drive level for one shared common or segment pin.
`timescale 1ns/100ps
module lcdcs_level_cell
  import lcdcs_pkg::*;
(
  input wire logic active_in, // Pin is driven by the LCD stage
  input wire logic frame_in, // Output frame phase
  input wire logic role_in, // 0 common, 1 segment
  input wire logic data_in, // Shared I/O data bit of the pin
  output logic [1:0] level_out // Chosen drive level code
);

  logic upper_set;

  // A segment pin in one frame uses the rail set of a common pin in the other.
  assign upper_set = ~(frame_in ^ role_in);

  always_comb begin
    if (!active_in) begin
      level_out = LCDCS_LVL_VSS;
    end else if (upper_set) begin
      level_out = data_in ? LCDCS_LVL_VDD : LCDCS_LVL_THIRD;
    end else begin
      level_out = data_in ? LCDCS_LVL_VSS : LCDCS_LVL_TWO_THIRDS;
    end
  end

endmodule

/* File: sim/lcdcs_lcd_panel.sv */
// Behavioural passive LCD panel that watches the drive level of every shared pin.
`timescale 1ns/100ps
module lcdcs_lcd_panel
  import lcdcs_pkg::*;
(
  input wire logic [LCDCS_NPIN-1:0] pin_active_in, // Pins driven by the stage
  input wire lcdcs_levels_t pin_level_in, // Level code per pin
  output logic all_vss_out // Every pin rests at ground
);
  // A passive panel only loads the pins, so it reports whether all of them sit at ground with none driven.
  always_comb begin
    all_vss_out = (pin_level_in == 40'h0) && (pin_active_in == 20'h00000);
  end
endmodule

/* File: sim/lcdcs_regs_tb.sv */
// Self-checking testbench for the LCD common/segment drive register bank.
`timescale 1ns/100ps
module lcdcs_regs_tb
  import lcdcs_pkg::*;
;
  logic sys_clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic [3:0] reg_addr_in = 4'h0;
  logic [7:0] reg_wdata_in = 8'h00;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic [19:0] io_data_in = 20'h00000;
  logic [19:0] lcd_func_in = 20'hFFFFE;
  logic [7:0] reg_rdata_out;
  logic lcd_driver_on_out;
  logic frame_out;
  logic [1:0] bias_resistor_select_out;
  logic [3:0] bias_ladder_out;
  logic [19:0] common_or_segment_role_out;
  logic [19:0] pin_active_out;
  lcdcs_levels_t pin_level_out;
  logic all_vss;
  int num_errors = 0;
  int tests_run = 0;
  int cycles = 0;

  lcdcs_regs lcdcs_regs_i (.sys_clk_in(sys_clk_in), .reset_in(reset_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .io_data_in(io_data_in),
    .lcd_func_in(lcd_func_in), .lcd_driver_on_out(lcd_driver_on_out),
    .frame_out(frame_out), .bias_resistor_select_out(bias_resistor_select_out),
    .bias_ladder_out(bias_ladder_out),
    .common_or_segment_role_out(common_or_segment_role_out),
    .pin_active_out(pin_active_out), .pin_level_out(pin_level_out));

  lcdcs_lcd_panel lcdcs_lcd_panel_i (.pin_active_in(pin_active_out),
    .pin_level_in(pin_level_out), .all_vss_out(all_vss));

  always #5 sys_clk_in = ~sys_clk_in;

  // The whole run needs well under a thousand cycles, so this only cuts a hang.
  always @(posedge sys_clk_in) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      conclude();
    end
  end

  // ----------------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------------
  task automatic check(input string what, input logic [39:0] exp, input logic [39:0] got);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk_in);
    reg_wr_in <= 1'b1;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge sys_clk_in);
    reg_wr_in <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge sys_clk_in);
    reg_rd_in <= 1'b1;
    reg_addr_in <= a;
    @(posedge sys_clk_in);
    reg_rd_in <= 1'b0;
    #1;
    check("reg_rdata_out", {32'h0, exp}, {32'h0, reg_rdata_out});
  endtask

  function automatic lcdcs_levels_t exp_lv(input logic [19:0] act, input logic fr,
                                           input logic [19:0] role, input logic [19:0] d);
    for (int i = 0; i < 20; i++) begin
      if (!act[i]) exp_lv[i] = LCDCS_LVL_VSS;
      else if (fr ^ role[i]) exp_lv[i] = d[i] ? LCDCS_LVL_VSS : LCDCS_LVL_TWO_THIRDS;
      else exp_lv[i] = d[i] ? LCDCS_LVL_VDD : LCDCS_LVL_THIRD;
    end
  endfunction

  // ----------------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------------
  task automatic t_reset();
    for (int a = 0; a < 4; a++) begin
      rd(a[3:0], 8'h00);
    end
    check("bias_ladder_out", 40'h1, {36'h0, bias_ladder_out});
    check("role", 40'h0, {20'h0, common_or_segment_role_out});
    check("driver_on", 40'h0, {39'h0, lcd_driver_on_out});
    check("frame", 40'h0, {39'h0, frame_out});
  endtask

  task automatic t_ctrl();
    wr(LCDCS_OFF_CTRL, 8'hFF);
    check("driver_on", 40'h1, {39'h0, lcd_driver_on_out});
    check("frame", 40'h1, {39'h0, frame_out});
    rd(LCDCS_OFF_CTRL, 8'hF0);
    for (int c = 0; c < 4; c++) begin
      wr(LCDCS_OFF_CTRL, {1'b0, c[1:0], 5'h00});
      check("bias_select", c, {38'h0, bias_resistor_select_out});
      check("bias_ladder_out", 40'h1 << c, {36'h0, bias_ladder_out});
      check("driver_on", 40'h0, {39'h0, lcd_driver_on_out});
      rd(LCDCS_OFF_CTRL, {1'b0, c[1:0], 5'h00});
    end
    rd(4'h4, 8'h00);
  endtask

  task automatic t_select();
    // Reserved positions stay unwritten; the absent top bits of the high register may be.
    wr(LCDCS_OFF_SEL_LOW, 8'hCF);
    wr(LCDCS_OFF_SEL_MID, 8'hDB);
    wr(LCDCS_OFF_SEL_HIGH, 8'hCF);
    rd(LCDCS_OFF_SEL_LOW, 8'hCF);
    rd(LCDCS_OFF_SEL_MID, 8'hDB);
    rd(LCDCS_OFF_SEL_HIGH, 8'h0F);
    check("role", {20'h0, LCDCS_PIN_IMPL}, {20'h0, common_or_segment_role_out});
    wr(LCDCS_OFF_SEL_LOW, 8'h81);
    wr(LCDCS_OFF_SEL_MID, 8'h90);
    wr(LCDCS_OFF_SEL_HIGH, 8'h05);
    check("role", 40'h59081, {20'h0, common_or_segment_role_out});
  endtask

  task automatic t_levels();
    logic [7:0] ctl [4] = '{8'h00, 8'h80, 8'h10, 8'h90};
    logic [19:0] dat [3] = '{20'h00000, 20'hFFFFF, 20'hA5A5A};
    logic [19:0] act;
    for (int c = 0; c < 4; c++) begin
      wr(LCDCS_OFF_CTRL, ctl[c]);
      for (int d = 0; d < 3; d++) begin
        @(posedge sys_clk_in);
        io_data_in <= dat[d];
        repeat (2) @(posedge sys_clk_in);
        #1;
        act = ctl[c][4] ? (lcd_func_in & LCDCS_PIN_IMPL) : 20'h00000;
        check("pin_active", {20'h0, act}, {20'h0, pin_active_out});
        check("pin_level", exp_lv(act, ctl[c][7], 20'h59081, dat[d]), pin_level_out);
        check("all_vss", {39'h0, !ctl[c][4]}, {39'h0, all_vss});
      end
    end
  endtask

  task automatic conclude();
    if (num_errors == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    repeat (2) @(posedge sys_clk_in);
    reset_in <= 1'b0;
    t_reset();
    t_ctrl();
    t_select();
    t_levels();
    conclude();
  end
endmodule
